// File: logic/npb_params.svh
`ifndef NPB_PARAMS_SVH
`define NPB_PARAMS_SVH
// Data memory addresses (7 bits)
`define NPB_ADDR_PORT_E 7'h6E
`define NPB_ADDR_PORT_F 7'h6F
`define NPB_ADDR_PORT_D 7'h73
`define NPB_ADDR_PORT_C 7'h72
// Register file addresses (6 bits)
`define NPB_RF_FUNC_SEL 6'h0B
`define NPB_RF_GRP_PU 6'h0C
`define NPB_RF_D_PU 6'h0D
`define NPB_RF_C_ANALOG 6'h1B
`define NPB_RF_C_DIR 6'h1C
`define NPB_RF_D_DIR 6'h2B
`define NPB_RF_GRP_DIR 6'h2C
// Field positions
`define NPB_BIT_SERIAL_SEL 0
`define NPB_BIT_TIMER1_SEL 3
`define NPB_BIT_GROUP_E 2
// Reset values
`define NPB_RST_NIBBLE 4'h0
`define NPB_RST_TIMER1_OUT 1'b1
`endif

// File: logic/npb_pkg.sv
package npb_pkg;
   typedef struct packed {
      logic we;
      logic re;
      logic [6:0] addr;
      logic [3:0] wdata;
   } npb_dm_req_s;
   typedef struct packed {
      logic we;
      logic re;
      logic [5:0] addr;
      logic [3:0] wdata;
   } npb_rf_req_s;
   typedef struct packed {
      logic sck_out;
      logic so_out;
      logic sck_internal;
      logic t1_reset;
      logic t1_match;
   } npb_periph_s;
   typedef struct packed {
      logic [3:0] c_latch;
      logic [3:0] c_dir;
      logic [3:0] c_analog;
      logic [3:0] d_latch;
      logic [3:0] d_dir;
      logic [3:0] d_pu;
      logic [3:0] func_sel;
      logic [3:0] grp_pu;
      logic [3:0] grp_dir;
      logic [3:0] e_latch;
      logic t1_out;
      logic [3:0] dm_rdata;
      logic [3:0] rf_rdata;
      logic [3:0] c_pin_o;
      logic [3:0] c_oe;
      logic [3:0] d_oe;
      logic [3:0] e_oe;
      logic [3:0] d_pu_en;
      logic [3:0] e_pu_en;
      logic [3:0] adc_en;
      logic vref_sel;
      logic standby_release;
      logic serial_in;
      logic sck_in;
   } npb_state_s;
endpackage

// File: logic/npb_ports.sv
// Summary of operation
// - Port D is a 4-bit open-drain latched port at data address 73H.
// - Port D per-pin direction in PORT_D_DIRECTION_BITS; zero reads pin level.
// - Port D direction one drives latch; read returns latch.
// - Port D per-pin pull-up enable in PORT_D_PULLUP_BITS.
// - Reset clears port D direction and latch, all inputs.
// - Direction change to input keeps port D latch.
// - PORT_D_FUNCTION_SELECT bit 0 maps D0..D2 to serial clock, out, in.
// - PORT_D_FUNCTION_SELECT bit 3 puts timer-1 toggle output on D3.
// - Alternate-mode reads: latch or pin depending on function.
// - Port E is 4-bit open-drain latched port at 6EH.
// - GROUP_DIRECTION_CONTROL bit 2 sets port E group direction and read source.
// - GROUP_PULLUP_CONTROL bit 2 enables all port E pull-ups.
// - Reset clears port E direction and latch.
// - Port F read at 6FH gives pins low, zeros high.
// - Writes to port F have no effect.
// - Any analog select makes F1 reference; bit 1 reads zero.
// - Port F pin 0 feeds the standby release signal.
// - Analog-selected port C pins keep latch writes, reads and drive.
// - Port C direction in 1CH, analog select in 1BH, reset cleared.
`timescale 1ns/1ps
`default_nettype none
`include "npb_params.svh"
module npb_ports (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // Data memory and register file access
   input wire npb_pkg::npb_dm_req_s dm_req_i,
   input wire npb_pkg::npb_rf_req_s rf_req_i,
   output logic [3:0] dm_rdata_o,
   output logic [3:0] rf_rdata_o,
   // Peripheral hooks
   input wire npb_pkg::npb_periph_s periph_i,
   output logic serial_in_o,
   output logic sck_in_o,
   output logic standby_release_o,
   output logic vref_sel_o,
   output logic [3:0] adc_en_o,
   // Port C pins (push-pull)
   input wire logic [3:0] port_c_i,
   output logic [3:0] port_c_o,
   output logic [3:0] port_c_oe_o,
   // Port D pins (open-drain, output held low)
   input wire logic [3:0] port_d_i,
   output logic [3:0] port_d_o,
   output logic [3:0] port_d_oe_o,
   output logic [3:0] port_d_pu_o,
   // Port E pins (open-drain)
   input wire logic [3:0] port_e_i,
   output logic [3:0] port_e_o,
   output logic [3:0] port_e_oe_o,
   output logic [3:0] port_e_pu_o,
   // Port F pins
   input wire logic [1:0] port_f_i
);
   import npb_pkg::*;

   npb_state_s state_reg;
   npb_state_s state_next;
   logic [3:0] d_drive;
   logic [3:0] d_read;
   logic [3:0] c_read;
   logic [3:0] e_read;
   logic [3:0] f_read;
   logic serial_on;
   logic timer_on;
   logic e_dir;

   always_comb begin
      serial_on = state_reg.func_sel[`NPB_BIT_SERIAL_SEL];
      timer_on = state_reg.func_sel[`NPB_BIT_TIMER1_SEL];
      e_dir = state_reg.grp_dir[`NPB_BIT_GROUP_E];
      // Value presented to each port D driver
      d_drive = state_reg.d_latch;
      if (serial_on) begin
         d_drive[0] = state_reg.func_sel[`NPB_BIT_SERIAL_SEL] ? periph_i.sck_out : state_reg.d_latch[0];
         d_drive[1] = periph_i.so_out;
      end
      if (timer_on) begin
         d_drive[3] = state_reg.t1_out;
      end
      // Port D read-back
      for (int i = 0; i < 4; i++) begin
         d_read[i] = state_reg.d_dir[i] ? state_reg.d_latch[i] : port_d_i[i];
      end
      if (serial_on) begin
         d_read[0] = periph_i.sck_internal ? state_reg.d_latch[0] : port_d_i[0];
         d_read[1] = state_reg.d_latch[1];
         d_read[2] = port_d_i[2];
      end
      if (timer_on) begin
         d_read[3] = state_reg.d_latch[3];
      end
      // Analog-selected C pins still read the latch
      for (int i = 0; i < 4; i++) begin
         c_read[i] = (state_reg.c_dir[i] || state_reg.c_analog[i]) ? state_reg.c_latch[i] : port_c_i[i];
      end
      e_read = e_dir ? state_reg.e_latch : port_e_i;
      f_read = {2'b00, (|state_reg.c_analog) ? 1'b0 : port_f_i[1], port_f_i[0]};

      state_next = state_reg;
      // Data memory writes; port F has no write path
      if (dm_req_i.we) begin
         case (dm_req_i.addr)
            `NPB_ADDR_PORT_D: state_next.d_latch = dm_req_i.wdata;
            `NPB_ADDR_PORT_E: state_next.e_latch = dm_req_i.wdata;
            `NPB_ADDR_PORT_C: state_next.c_latch = dm_req_i.wdata;
            default: state_next.c_latch = state_reg.c_latch;
         endcase
      end
      // Register file writes; direction changes leave latches alone
      if (rf_req_i.we) begin
         case (rf_req_i.addr)
            `NPB_RF_FUNC_SEL: state_next.func_sel = rf_req_i.wdata;
            `NPB_RF_GRP_PU: state_next.grp_pu = rf_req_i.wdata;
            `NPB_RF_D_PU: state_next.d_pu = rf_req_i.wdata;
            `NPB_RF_C_ANALOG: state_next.c_analog = rf_req_i.wdata;
            `NPB_RF_C_DIR: state_next.c_dir = rf_req_i.wdata;
            `NPB_RF_D_DIR: state_next.d_dir = rf_req_i.wdata;
            `NPB_RF_GRP_DIR: state_next.grp_dir = rf_req_i.wdata;
            default: state_next.grp_dir = state_reg.grp_dir;
         endcase
      end
      // Timer-1 toggle: set at timer reset, else invert on each match; reset wins when both come in one cycle
      if (periph_i.t1_reset) begin
         state_next.t1_out = `NPB_RST_TIMER1_OUT;
      end else if (periph_i.t1_match) begin
         state_next.t1_out = ~state_reg.t1_out;
      end
      // Read data registered, one cycle latency
      state_next.dm_rdata = 4'h0;
      if (dm_req_i.re) begin
         case (dm_req_i.addr)
            `NPB_ADDR_PORT_D: state_next.dm_rdata = d_read;
            `NPB_ADDR_PORT_E: state_next.dm_rdata = e_read;
            `NPB_ADDR_PORT_F: state_next.dm_rdata = f_read;
            `NPB_ADDR_PORT_C: state_next.dm_rdata = c_read;
            default: state_next.dm_rdata = 4'h0;
         endcase
      end
      state_next.rf_rdata = 4'h0;
      if (rf_req_i.re) begin
         case (rf_req_i.addr)
            `NPB_RF_FUNC_SEL: state_next.rf_rdata = state_reg.func_sel;
            `NPB_RF_GRP_PU: state_next.rf_rdata = state_reg.grp_pu;
            `NPB_RF_D_PU: state_next.rf_rdata = state_reg.d_pu;
            `NPB_RF_C_ANALOG: state_next.rf_rdata = state_reg.c_analog;
            `NPB_RF_C_DIR: state_next.rf_rdata = state_reg.c_dir;
            `NPB_RF_D_DIR: state_next.rf_rdata = state_reg.d_dir;
            `NPB_RF_GRP_DIR: state_next.rf_rdata = state_reg.grp_dir;
            default: state_next.rf_rdata = 4'h0;
         endcase
      end
      // Pin drivers: open-drain enables pull low only when driving zero
      state_next.c_pin_o = state_reg.c_latch;
      state_next.c_oe = state_reg.c_dir;
      for (int i = 0; i < 4; i++) begin
         state_next.d_oe[i] = state_reg.d_dir[i] & ~d_drive[i];
         state_next.e_oe[i] = e_dir & ~state_reg.e_latch[i];
      end
      // Serial and timer outputs drive regardless of the direction bit
      if (serial_on) begin
         state_next.d_oe[0] = periph_i.sck_internal ? ~d_drive[0] : 1'b0;
         state_next.d_oe[1] = ~d_drive[1];
         state_next.d_oe[2] = 1'b0;
      end
      if (timer_on) begin
         state_next.d_oe[3] = ~d_drive[3];
      end
      state_next.d_pu_en = state_reg.d_pu;
      state_next.e_pu_en = {4{state_reg.grp_pu[`NPB_BIT_GROUP_E]}};
      state_next.adc_en = state_reg.c_analog;
      state_next.vref_sel = |state_reg.c_analog;
      state_next.standby_release = port_f_i[0];
      state_next.serial_in = port_d_i[2];
      state_next.sck_in = port_d_i[0];

      if (srst_i) begin
         state_next = '0;
         state_next.t1_out = `NPB_RST_TIMER1_OUT;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      state_reg <= state_next;
   end

   assign dm_rdata_o = state_reg.dm_rdata;
   assign rf_rdata_o = state_reg.rf_rdata;
   assign serial_in_o = state_reg.serial_in;
   assign sck_in_o = state_reg.sck_in;
   assign standby_release_o = state_reg.standby_release;
   assign vref_sel_o = state_reg.vref_sel;
   assign adc_en_o = state_reg.adc_en;
   assign port_c_o = state_reg.c_pin_o;
   assign port_c_oe_o = state_reg.c_oe;
   assign port_d_o = 4'h0;
   assign port_d_oe_o = state_reg.d_oe;
   assign port_d_pu_o = state_reg.d_pu_en;
   assign port_e_o = 4'h0;
   assign port_e_oe_o = state_reg.e_oe;
   assign port_e_pu_o = state_reg.e_pu_en;

   // Assertions
   sequence d_latch_write_s;
      dm_req_i.we && dm_req_i.addr == `NPB_ADDR_PORT_D;
   endsequence

   d_latch_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      d_latch_write_s |=> state_reg.d_latch == $past(dm_req_i.wdata))
      else $error("port D latch not loaded");
   d_input_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_D && !state_reg.func_sel[0] && !state_reg.func_sel[3]
      && state_reg.d_dir == 4'h0 |=> dm_rdata_o == $past(port_d_i))
      else $error("port D input read wrong");
   d_out_low_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      state_reg.func_sel == 4'h0 && state_reg.d_dir[3] && !state_reg.d_latch[3] |=> port_d_oe_o[3])
      else $error("port D pin not driven low");
   d_pullup_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ##1 port_d_pu_o == $past(state_reg.d_pu))
      else $error("port D pull-up mismatch");
   reset_clear_a: assert property (@(posedge sys_clk_i)
      srst_i |=> state_reg.d_dir == 4'h0 && state_reg.d_latch == 4'h0 && !port_e_oe_o[0] && !port_d_oe_o[0])
      else $error("reset did not clear ports");
   dir_keep_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      !dm_req_i.we |=> state_reg.d_latch == $past(state_reg.d_latch))
      else $error("port D latch changed");
   timer_toggle_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      periph_i.t1_match && !periph_i.t1_reset |=> state_reg.t1_out != $past(state_reg.t1_out))
      else $error("timer output did not toggle");
   serial_in_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_D && state_reg.func_sel[0]
      |=> dm_rdata_o[2] == $past(port_d_i[2]) && dm_rdata_o[1] == $past(state_reg.d_latch[1]))
      else $error("serial mode read wrong");
   e_group_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      !state_reg.grp_dir[2] |=> port_e_oe_o == 4'h0)
      else $error("port E drives in input mode");
   f_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_F |=> dm_rdata_o[3:2] == 2'b00
      && dm_rdata_o[0] == $past(port_f_i[0]))
      else $error("port F read wrong");
   vref_zero_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_F && |state_reg.c_analog |=> !dm_rdata_o[1])
      else $error("reference bit not zero");

   e_latch_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.we && dm_req_i.addr == `NPB_ADDR_PORT_E |=> state_reg.e_latch == $past(dm_req_i.wdata))
      else $error("port E latch not loaded");

   f_no_write_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.we && dm_req_i.addr == `NPB_ADDR_PORT_F |=> state_reg.e_latch == $past(state_reg.e_latch))
      else $error("port F write changed a latch");

   d_pu_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rf_req_i.we && rf_req_i.addr == `NPB_RF_D_PU |=> state_reg.d_pu == $past(rf_req_i.wdata))
      else $error("port D pull-up bits not loaded");

   grp_dir_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rf_req_i.we && rf_req_i.addr == `NPB_RF_GRP_DIR |=> state_reg.grp_dir == $past(rf_req_i.wdata))
      else $error("group direction not loaded");

   e_pullup_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ##1 port_e_pu_o == {4{$past(state_reg.grp_pu[`NPB_BIT_GROUP_E])}})
      else $error("port E pull-up mismatch");

   e_read_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_E && state_reg.grp_dir[2] |=> dm_rdata_o == $past(state_reg.e_latch))
      else $error("port E output read wrong");

   e_read_pin_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_E && !state_reg.grp_dir[2] |=> dm_rdata_o == $past(port_e_i))
      else $error("port E input read wrong");

   e_drive_low_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      state_reg.grp_dir[2] |=> port_e_oe_o == ~$past(state_reg.e_latch))
      else $error("port E driver mismatch");

   reset_e_clear_a: assert property (@(posedge sys_clk_i)
      srst_i |=> state_reg.grp_dir == 4'h0 && state_reg.e_latch == 4'h0 && port_e_oe_o == 4'h0)
      else $error("reset did not clear port E");

   reset_c_clear_a: assert property (@(posedge sys_clk_i)
      srst_i |=> state_reg.c_dir == 4'h0 && state_reg.c_analog == 4'h0 && port_c_oe_o == 4'h0)
      else $error("reset did not clear port C");

   vref_sel_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ##1 vref_sel_o == ($past(state_reg.c_analog) != 4'h0))
      else $error("reference select mismatch");

   standby_copy_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      ##1 standby_release_o == $past(port_f_i[0]))
      else $error("standby release mismatch");

   c_read_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_C && state_reg.c_analog[0] |=> dm_rdata_o[0] == $past(state_reg.c_latch[0]))
      else $error("analog port C read wrong");

   c_drive_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      state_reg.c_dir[0] |=> port_c_oe_o[0] && port_c_o[0] == $past(state_reg.c_latch[0]))
      else $error("port C pin not driven");

   c_dir_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rf_req_i.we && rf_req_i.addr == `NPB_RF_C_DIR |=> state_reg.c_dir == $past(rf_req_i.wdata))
      else $error("port C direction not loaded");

   c_analog_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rf_req_i.we && rf_req_i.addr == `NPB_RF_C_ANALOG |=> state_reg.c_analog == $past(rf_req_i.wdata))
      else $error("analog select not loaded");

   func_sel_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rf_req_i.we && rf_req_i.addr == `NPB_RF_FUNC_SEL |=> state_reg.func_sel == $past(rf_req_i.wdata))
      else $error("function select not loaded");

   si_drive_off_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      state_reg.func_sel[0] |=> !port_d_oe_o[2])
      else $error("serial input pin driven");

   so_drive_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      state_reg.func_sel[0] |=> port_d_oe_o[1] == !$past(periph_i.so_out))
      else $error("serial output pin mismatch");

   timer_drive_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      state_reg.func_sel[3] |=> port_d_oe_o[3] == !$past(state_reg.t1_out))
      else $error("timer output pin mismatch");

   timer_reset_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      periph_i.t1_reset |=> state_reg.t1_out)
      else $error("timer output not set at timer reset");

   d_dir_load_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rf_req_i.we && rf_req_i.addr == `NPB_RF_D_DIR |=> state_reg.d_dir == $past(rf_req_i.wdata))
      else $error("port D direction not loaded");

   d_read_latch_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_D && state_reg.func_sel == 4'h0
      && state_reg.d_dir == 4'hF |=> dm_rdata_o == $past(state_reg.d_latch))
      else $error("port D output read wrong");

   sck_read_int_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_D && state_reg.func_sel[0] && periph_i.sck_internal
      |=> dm_rdata_o[0] == $past(state_reg.d_latch[0]))
      else $error("internal clock read wrong");

   timer_read_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      dm_req_i.re && dm_req_i.addr == `NPB_ADDR_PORT_D && state_reg.func_sel[3] |=> dm_rdata_o[3] == $past(state_reg.d_latch[3]))
      else $error("timer pin read wrong");

   d_oe_reset_a: assert property (@(posedge sys_clk_i)
      srst_i |=> port_d_oe_o == 4'h0 && port_d_pu_o == 4'h0)
      else $error("port D drives after reset");

   d_pu_reset_a: assert property (@(posedge sys_clk_i)
      srst_i |=> state_reg.d_pu == 4'h0 && port_e_pu_o == 4'h0)
      else $error("pull-ups on after reset");

   rdata_idle_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      !dm_req_i.re |=> dm_rdata_o == 4'h0)
      else $error("read data not cleared");
endmodule
`default_nettype wire

// File: verif/npb_pins_model.sv
`timescale 1ns/1ps
`default_nettype none
// Board side: on D and E, chip pulls low, else outside driver, else pull-up, else floating; on C, chip drives, else outside driver
module npb_pins_model (
   // Chip side
   input wire logic clk_i,
   input wire logic [3:0] d_oe_i, d_pu_i, e_oe_i, e_pu_i, c_o_i, c_oe_i,
   // Outside drivers
   input wire logic [3:0] d_x_i, d_xen_i, e_x_i, e_xen_i, c_x_i,
   // Resolved pin levels
   output logic [3:0] d_lvl_o, e_lvl_o, c_lvl_o
);
   // Floating lines wander each cycle so a stale level cannot pass
   logic [3:0] flt = 4'h5;
   always @(posedge clk_i) begin
      flt <= ~flt;
   end
   assign d_lvl_o = ~d_oe_i & ((d_xen_i & d_x_i) | (~d_xen_i & (d_pu_i | flt)));
   assign e_lvl_o = ~e_oe_i & ((e_xen_i & e_x_i) | (~e_xen_i & (e_pu_i | flt)));
   assign c_lvl_o = (c_oe_i & c_o_i) | (~c_oe_i & c_x_i);
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import npb_pkg::*;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   npb_dm_req_s dm = '0;
   npb_rf_req_s rf = '0;
   npb_periph_s pe = '0;
   logic [3:0] dmr, rfr, c_o, c_oe, d_oe, d_pu, e_oe, e_pu, adc, c_l, d_l, e_l;
   logic [3:0] dx = 4'hA;
   logic [1:0] fp = 2'h2;
   logic si, sck, standby_release_input, vref;
   int failures = 0;
   int n_checks = 0;

   npb_ports u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .dm_req_i(dm), .rf_req_i(rf),
      .dm_rdata_o(dmr), .rf_rdata_o(rfr), .periph_i(pe), .serial_in_o(si), .sck_in_o(sck),
      .standby_release_o(standby_release_input), .vref_sel_o(vref), .adc_en_o(adc), .port_c_i(c_l), .port_c_o(c_o),
      .port_c_oe_o(c_oe), .port_d_i(d_l), .port_d_o(), .port_d_oe_o(d_oe), .port_d_pu_o(d_pu),
      .port_e_i(e_l), .port_e_o(), .port_e_oe_o(e_oe), .port_e_pu_o(e_pu), .port_f_i(fp));
   npb_pins_model u_pins (.clk_i(sys_clk_i), .d_oe_i(d_oe), .d_pu_i(d_pu), .e_oe_i(e_oe),
      .e_pu_i(e_pu), .c_o_i(c_o), .c_oe_i(c_oe), .d_x_i(dx), .d_xen_i(4'hF), .e_x_i(4'h6),
      .e_xen_i(4'hF), .c_x_i(4'hA), .d_lvl_o(d_l), .e_lvl_o(e_l), .c_lvl_o(c_l));

   initial begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   task automatic end_sim;
      if (failures == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [3:0] e, input logic [3:0] s);
      n_checks++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask

   // One access; the trailing idle cycles let pin outputs catch up
   task automatic acc(input logic r, input logic w, input logic [6:0] a, input logic [3:0] wd,
      output logic [3:0] rd);
      @(negedge sys_clk_i);
      if (r) begin
         rf = '{w, !w, a[5:0], wd};
      end else begin
         dm = '{w, !w, a, wd};
      end
      @(negedge sys_clk_i);
      // Read data stands one cycle only
      rd = r ? rfr : dmr;
      dm = '0;
      rf = '0;
      repeat (3) @(negedge sys_clk_i);
   endtask

   task automatic wr(input logic r, input logic [6:0] a, input logic [3:0] d);
      logic [3:0] x;
      acc(r, 1'b1, a, d, x);
   endtask

   task automatic rd_chk(input string n, input logic r, input logic [6:0] a, input logic [3:0] e);
      logic [3:0] x;
      acc(r, 1'b0, a, 4'h0, x);
      chk(n, e, x);
   endtask

   task automatic t1_pulse(input logic m);
      pe.t1_match = m;
      pe.t1_reset = !m;
      @(negedge sys_clk_i);
      pe.t1_match = 1'b0;
      pe.t1_reset = 1'b0;
      repeat (3) @(negedge sys_clk_i);
   endtask

   task automatic t_reset;
      chk("d_oe", 4'h0, d_oe);
      chk("e_oe", 4'h0, e_oe);
      rd_chk("d_dir", 1, 7'h2B, 4'h0);
      rd_chk("g_dir", 1, 7'h2C, 4'h0);
      rd_chk("c_dir", 1, 7'h1C, 4'h0);
      rd_chk("c_ana", 1, 7'h1B, 4'h0);
      rd_chk("d_pin", 0, 7'h73, 4'hA);
      rd_chk("e_pin", 0, 7'h6E, 4'h6);
   endtask

   task automatic t_port_d;
      wr(1, 7'h2B, 4'hF);
      rd_chk("d_lat", 0, 7'h73, 4'h0);
      wr(0, 7'h73, 4'h5);
      chk("d_oe", 4'hA, d_oe);
      rd_chk("d_out", 0, 7'h73, 4'h5);
      wr(1, 7'h2B, 4'h3);
      rd_chk("d_mix", 0, 7'h73, 4'h9);
      wr(1, 7'h2B, 4'h0);
      chk("d_oe", 4'h0, d_oe);
      wr(1, 7'h2B, 4'hF);
      rd_chk("d_keep", 0, 7'h73, 4'h5);
      wr(1, 7'h0D, 4'h9);
      chk("d_pu", 4'h9, d_pu);
   endtask

   task automatic t_port_e;
      wr(0, 7'h6E, 4'h3);
      wr(1, 7'h2C, 4'h4);
      chk("e_oe", 4'hC, e_oe);
      rd_chk("e_lat", 0, 7'h6E, 4'h3);
      wr(1, 7'h0C, 4'h4);
      chk("e_pu", 4'hF, e_pu);
      wr(1, 7'h2C, 4'h0);
      rd_chk("e_in", 0, 7'h6E, 4'h6);
   endtask

   task automatic t_port_fc;
      rd_chk("f_rd", 0, 7'h6F, 4'h2);
      fp = 2'h3;
      wr(0, 7'h6F, 4'h0);
      rd_chk("f_wr", 0, 7'h6F, 4'h3);
      chk("rls", 4'h1, {3'h0, standby_release_input});
      wr(1, 7'h1B, 4'h1);
      chk("vref", 4'h1, {3'h0, vref});
      chk("adc", 4'h1, adc);
      rd_chk("f_ref", 0, 7'h6F, 4'h1);
      wr(0, 7'h72, 4'h1);
      rd_chk("c_ana", 0, 7'h72, 4'hB);
      wr(1, 7'h1C, 4'h1);
      chk("c_oe", 4'h1, c_oe);
      chk("c_o", 4'h1, c_o & 4'h1);
      wr(1, 7'h1C, 4'h0);
   endtask

   task automatic t_serial;
      wr(0, 7'h73, 4'h1);
      dx = 4'hE;
      pe = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      wr(1, 7'h0B, 4'h1);
      chk("sio_oe", 4'hB, d_oe);
      chk("si", 4'h1, {3'h0, si});
      chk("sck", 4'h0, {3'h0, sck});
      rd_chk("fsel", 1, 7'h0B, 4'h1);
      pe.sck_out = 1'b1;
      pe.so_out = 1'b1;
      rd_chk("sio_rd", 0, 7'h73, 4'h5);
      chk("sio_oe", 4'h8, d_oe);
      pe.sck_internal = 1'b0;
      rd_chk("sck_ext", 0, 7'h73, 4'h4);
   endtask

   task automatic t_timer;
      wr(1, 7'h0B, 4'h8);
      t1_pulse(1'b1);
      chk("t1_m", 4'h8, d_oe & 4'h8);
      t1_pulse(1'b0);
      chk("t1_r", 4'h0, d_oe & 4'h8);
      rd_chk("t1_rd", 0, 7'h73, 4'h1);
      t1_pulse(1'b1);
      chk("t1_m", 4'h8, d_oe & 4'h8);
   endtask

   // Hang guard
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      failures++;
      end_sim();
   end

   initial begin
      repeat (12) @(negedge sys_clk_i);
      srst_i = 1'b0;
      t_reset();
      t_port_d();
      t_port_e();
      t_port_fc();
      t_serial();
      t_timer();
      end_sim();
   end
endmodule
`default_nettype wire
